// file: input_sync.sv
// Three-stage synchroniser for a vector of pins from outside the clock.
// A bit's filtered level changes only when stages two and three agree.
`timescale 1ns/100ps
module input_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;

  // Agreement takes the new value, disagreement holds the old one
  assign level_nxt = (s2_r & s3_r) | (level_o & (s2_r | s3_r));

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s1_r    <= INIT;
      s2_r    <= INIT;
      s3_r    <= INIT;
      level_o <= INIT;
    end
    else
    begin
      s1_r    <= async_i;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_o <= level_nxt;
    end
  end

endmodule : input_sync

// file: tb_top.sv
// Bench for the image upgrade register block; it plays the engine and
// the pins. Assumes the user logic model drives the serial port.
`timescale 1ns/100ps
module tb_top;
  import upgrade_pkg::*;
  localparam logic [CTRL_W-1:0] W1 = {5'h09, 22'h12D687, 12'hA5C};
  localparam logic [CTRL_W-1:0] E1 = {5'h18, 22'h12D687, 12'hA5C};
  localparam logic [CTRL_W-1:0] W2 = {5'h18, 22'h3FFFFF, 12'hFFF};
  localparam logic [CTRL_W-1:0] W3 = {5'h16, 22'h000040, 12'h000};
  logic              mclk_i  = 1'b0;
  logic              reset_i = 1'b1;
  logic              reqn_r  = 1'b1;
  logic              cfgn_r  = 1'b1;
  logic              done_r  = 1'b0;
  logic              scheme_r = 1'b0;
  logic              crc_r   = 1'b0;
  logic              fload_r = 1'b0;
  logic [ADDR_W-1:0] faddr_r = '0;
  logic              rclk, sin, shsel, cpsel, stsel;
  logic              sout, start, fact, early, osc, wden;
  logic [ADDR_W-1:0] boot;
  logic [CTRL_W-1:0] q;
  int                num_errors = 0;
  int                checked    = 0;

  always #10 mclk_i = ~mclk_i;

  user_logic_model u_user (.mclk_i(mclk_i), .serial_out_i(sout),
    .reg_clock_o(rclk), .serial_in_o(sin), .shift_sel_o(shsel),
    .capture_sel_o(cpsel), .status_sel_o(stsel));

  // Kick, device error pin and remote mode are held: watchdog must expire
  upgrade_regs dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .upgrade_reg_clock_i(rclk), .serial_in_i(sin),
    .shift_not_load_sel_i(shsel), .capture_not_update_sel_i(cpsel),
    .status_sel_i(stsel), .reconfigure_request_n_i(reqn_r),
    .watchdog_kick_n_i(1'b1), .config_reset_n_i(cfgn_r),
    .device_error_n_i(1'b1), .crc_error_i(crc_r),
    .config_complete_flag_i(done_r), .remote_mode_i(1'b1),
    .active_parallel_scheme_i(scheme_r), .factory_address_load_i(fload_r),
    .factory_address_i(faddr_r), .serial_out_o(sout),
    .boot_address_o(boot), .reconfig_start_o(start),
    .factory_image_o(fact), .early_done_check_o(early),
    .osc_select_o(osc), .watchdog_enable_o(wden));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [CTRL_W-1:0] exp,
                       input logic [CTRL_W-1:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waits up to 400 cycles for the start pulse, then two cycles later raises the done flag for one cycle
  task automatic reboot();
    int n;
    n = 0;
    while (start !== 1'b1 && n < 400)
    begin
      @(posedge mclk_i);
      #1 n++;
    end
    check("start seen", 39'h1, CTRL_W'(n < 400));
    if (n == 400)
      give_verdict();
    repeat (2) @(posedge mclk_i);
    #1 done_r = 1'b1;
    @(posedge mclk_i);
    #1 done_r = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask : reboot

  task automatic pin_reboot(input logic cfg);
    if (cfg)
      cfgn_r = 1'b0;
    else
      reqn_r = 1'b0;
    reboot();
    cfgn_r = 1'b1;
    reqn_r = 1'b1;
  endtask : pin_reboot

  task automatic do_reset(input logic scheme);
    reset_i = 1'b1;
    scheme_r = scheme;
    repeat (4) @(posedge mclk_i);
    check("boot in reset", '0, CTRL_W'(boot));
    #1 reset_i = 1'b0;
    reboot();
  endtask : do_reset

  initial
  begin
    do_reset(1'b0);
    check("serial factory boot", '0, CTRL_W'(boot));
    check("factory flag", 39'h1, CTRL_W'(fact));
    u_user.write_word(W1);
    u_user.read_word(1'b0, q);
    check("update readback", E1, q);
    u_user.read_word(1'b1, q);
    check("factory word", 39'h4000_0000, {7'h00, q[31:0]});
    $display("test factory access done");
    pin_reboot(1'b0);
    check("app boot", {15'h0, 22'h12D687, 2'h0}, CTRL_W'(boot));
    check("app options", 39'h4, {36'h0, early, osc, wden});
    u_user.read_word(1'b0, q);
    check("control in app", E1, q);
    u_user.write_word(W2);
    pin_reboot(1'b0);
    u_user.read_word(1'b1, q);
    check("user cause", {7'h04, 32'h4000_0000}, q);
    u_user.read_word(1'b0, q);
    check("update kept", E1, q);
    $display("test application access done");
    u_user.write_word(W3);
    pin_reboot(1'b0);
    check("wd options", 39'h3, {36'h0, early, osc, wden});
    check("wd app boot", 39'h100, CTRL_W'(boot));
    reboot();
    u_user.read_word(1'b1, q);
    check("wd cause", {7'h08, 32'h4000_0000}, q);
    $display("test watchdog done");
    do_reset(1'b1);
    check("parallel boot", 39'h01_0000, CTRL_W'(boot));
    faddr_r = 24'h0ABC00;
    fload_r = 1'b1;
    @(posedge mclk_i);
    #1 fload_r = 1'b0;
    pin_reboot(1'b1);
    check("new factory boot", 39'h0A_BC00, CTRL_W'(boot));
    crc_r = 1'b1;
    @(posedge mclk_i);
    #1 crc_r = 1'b0;
    reboot();
    u_user.read_word(1'b1, q);
    check("crc cause", {7'h20, 32'h400A_BC00}, q);
    $display("test parallel scheme done");
    give_verdict();
  end
endmodule : tb_top

// file: upgrade_pkg.sv
// Constants, field layouts and state codes of the image upgrade register block.
// Assumes a single 50 MHz clock standing in for the internal oscillator.
package upgrade_pkg;

  localparam int CTRL_W     = 39;
  localparam int STAT_W     = 32;
  localparam int ADDR_W     = 24;
  localparam int WD_FIELD_W = 12;
  localparam int WD_CNT_W   = 29;
  localparam int CAUSE_W    = 5;

  // Control register field positions
  localparam int CTL_RSV_HIGH  = 38;
  localparam int CTL_EARLY_DN  = 37;
  localparam int CTL_OSC_SEL   = 36;
  localparam int CTL_WDOG_ON   = 35;
  localparam int CTL_RSV_LOW   = 34;
  localparam int CTL_ADDR_MSB  = 33;
  localparam int CTL_ADDR_LSB  = 12;
  localparam int CTL_WD_MSB    = 11;
  localparam int CTL_WD_LSB    = 0;

  // Status word field positions
  localparam int ST_STATE_MSB  = 31;
  localparam int ST_STATE_LSB  = 30;
  localparam int ST_WDEN_BIT   = 29;
  localparam int ST_CAUSE_MSB  = 38;

  // Reset values and fixed patterns
  localparam logic [CTRL_W-1:0] CTRL_RESET =
    39'h40_0000_0000;
  localparam logic [ADDR_W-1:0] SERIAL_FACTORY_ADDR   = 24'h000000;
  localparam logic [ADDR_W-1:0] PARALLEL_FACTORY_ADDR = 24'h010000;
  localparam logic [16:0]       WD_LOW_PATTERN  = 17'h00008;
  localparam logic [1:0]        ADDR_PAD        = 2'h0;

  // Cause bits, highest index wins a tie
  localparam int CAUSE_PIN_RESET = 4;
  localparam int CAUSE_CRC       = 3;
  localparam int CAUSE_DEV_ERR   = 2;
  localparam int CAUSE_WATCHDOG  = 1;
  localparam int CAUSE_USER_REQ  = 0;

  typedef enum logic [1:0] {
    ST_POWERUP  = 2'b00,
    ST_FACTORY  = 2'b01,
    ST_APP      = 2'b10,
    ST_RECONFIG = 2'b11
  } master_state_t;

endpackage : upgrade_pkg

// file: upgrade_regs.sv
// Image upgrade register block: shift, update, control and status
// registers, master state and watchdog hookup.
// Assumes the user-side pins are asynchronous to mclk_i and that the
// configuration engine shares mclk_i.
`timescale 1ns/100ps
//
// Contract
// - User logic reaches update, status and control through a shift register.
// - Update writes allowed only in factory image in remote mode.
// - Read in application image copies control into shift register.
// - Read in factory image copies update into shift register.
// - Update changes only by factory shift-in then update operation; here its address field also takes the power-up preset.
// - Each reconfiguration start loads control from update.
// - Each reconfiguration writes its cause into status register.
// - Capture cycle copies status into the shift register.
// - Control and status run on oscillator clock or alternate user clock; here both run on mclk_i only.
// - Shift and update follow register clock, at most 40 MHz; here they run on mclk_i and act on synchronised register clock rises.
// - Serial scheme clears control address to zero at power up.
// - Parallel scheme presets control address to factory location.
// - Parallel scheme factory address replaceable by dedicated instruction.
// - Control layout: rsv, early check, osc, wd enable, rsv, addr, wd.
// - Watchdog runs for application image when enable bit set.
// - Watchdog field forms top 12 bits of 29-bit count.
// - Boot address is address field with two zero bits appended.
// - Control holds early done check and oscillator select bits.
// - Low reserved bit held zero, high reserved bit held one.
// - Factory status word shows master state and boot address.
module upgrade_regs
  import upgrade_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic                      upgrade_reg_clock_i,
  input  wire logic                      serial_in_i,
  input  wire logic                      shift_not_load_sel_i,
  input  wire logic                      capture_not_update_sel_i,
  input  wire logic                      status_sel_i,
  input  wire logic                      reconfigure_request_n_i,
  input  wire logic                      watchdog_kick_n_i,
  input  wire logic                      config_reset_n_i,
  input  wire logic                      device_error_n_i,
  input  wire logic                      crc_error_i,
  input  wire logic                      config_complete_flag_i,
  input  wire logic                      remote_mode_i,
  input  wire logic                      active_parallel_scheme_i,
  input  wire logic                      factory_address_load_i,
  input  wire logic [upgrade_pkg::ADDR_W-1:0] factory_address_i,
  output logic                           serial_out_o,
  output logic [upgrade_pkg::ADDR_W-1:0] boot_address_o,
  output logic                           reconfig_start_o,
  output logic                           factory_image_o,
  output logic                           early_done_check_o,
  output logic                           osc_select_o,
  output logic                           watchdog_enable_o
);

  // Synchronised pins, order fixed by the concatenation below
  localparam int NSYNC = 9;
  localparam logic [NSYNC-1:0] SYNC_INIT = 9'h0EF; // Pin idle levels

  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_lvl;
  logic             rclk_lvl;
  logic             sin_lvl;
  logic             shift_lvl;
  logic             capt_lvl;
  logic             stsel_lvl;
  logic             reqn_lvl;
  logic             kickn_lvl;
  logic             rstn_lvl;
  logic             errn_lvl;

  assign pins_raw = {upgrade_reg_clock_i, serial_in_i,
                     shift_not_load_sel_i, capture_not_update_sel_i,
                     status_sel_i, reconfigure_request_n_i,
                     watchdog_kick_n_i, config_reset_n_i,
                     device_error_n_i};
  assign {rclk_lvl, sin_lvl, shift_lvl, capt_lvl, stsel_lvl,
          reqn_lvl, kickn_lvl, rstn_lvl, errn_lvl} = pins_lvl;

  input_sync #(
    .W    (NSYNC),
    .INIT (SYNC_INIT)
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (pins_raw),
    .level_o (pins_lvl)
  );

  // Registers
  master_state_t         state_r;
  master_state_t         state_nxt;
  logic                  target_app_r;
  logic [CTRL_W-1:0]     shift_r;
  logic [CTRL_W-1:0]     shift_nxt;
  logic [CTRL_W-1:0]     update_r;
  logic [CTRL_W-1:0]     control_r;
  logic [STAT_W-1:0]     status_cur;
  logic [CAUSE_W-1:0]    cause_r;
  logic [ADDR_W-1:0]     cur_boot_r;
  logic [ADDR_W-1:0]     factory_addr_r;
  logic                  straps_taken_r;
  logic                  remote_r;
  logic                  parallel_r;
  logic                  rclk_d_r;
  logic                  reqn_d_r;
  logic                  rstn_d_r;
  logic                  errn_d_r;
  logic                  kickn_d_r;

  // Edge and event decode
  logic                  rclk_rise;
  logic                  user_req;
  logic                  pin_reset;
  logic                  dev_err;
  logic                  kick;
  logic                  wd_expired;
  logic                  in_factory;
  logic                  in_app;
  logic [CAUSE_W-1:0]    cause_vec;
  logic [CAUSE_W-1:0]    cause_win;
  logic                  any_cause;
  logic                  do_shift;
  logic                  do_capture;
  logic                  do_update;
  logic                  update_ok;
  logic [CTRL_W-1:0]     read_word;
  logic [ADDR_W-1:0]     next_boot;
  logic [ADDR_W-1:0]     update_boot;
  logic [WD_CNT_W-1:0]   wd_count_cur;

  // Keeps a boot address field inside the control layout
  function automatic logic [21:0] addr_field(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : addr_field

  // Forces both reserved control bits to their held values
  function automatic logic [CTRL_W-1:0] fix_reserved(
    input logic [CTRL_W-1:0] w
  );
    logic [CTRL_W-1:0] r;
    r               = w;
    r[CTL_RSV_LOW]  = 1'b0;
    r[CTL_RSV_HIGH] = 1'b1;
    return r;
  endfunction : fix_reserved

  // Only the rising edge of the register clock moves the shift path
  assign rclk_rise  = rclk_lvl && !rclk_d_r;
  assign user_req   = !reqn_lvl && reqn_d_r;
  assign pin_reset  = !rstn_lvl && rstn_d_r;
  assign dev_err    = !errn_lvl && errn_d_r;
  assign kick       = !kickn_lvl && kickn_d_r;
  assign in_factory = (state_r == ST_FACTORY);
  assign in_app     = (state_r == ST_APP);

  assign do_shift   = rclk_rise && shift_lvl;
  assign do_capture = rclk_rise && !shift_lvl && capt_lvl;
  assign do_update  = rclk_rise && !shift_lvl && !capt_lvl;
  assign update_ok  = do_update && in_factory && remote_r;

  // Read source: status on request, else update or control by image
  assign status_cur = in_factory ?
    {state_r, 6'h00, cur_boot_r} :
    {state_r, control_r[CTL_WDOG_ON], wd_count_cur};
  assign read_word  = stsel_lvl ?
    {cause_r, 2'h0, status_cur} :
    (in_factory ? update_r : control_r);

  assign shift_nxt  = do_shift ?
    {sin_lvl, shift_r[CTRL_W-1:1]} :
    (do_capture ? read_word : shift_r);

  assign wd_count_cur = {control_r[CTL_WD_MSB:CTL_WD_LSB],
                         WD_LOW_PATTERN};

  // Reconfiguration causes; every cause, the user logic request included,
  // counts only once an image is running
  assign cause_vec[CAUSE_PIN_RESET] = pin_reset;
  assign cause_vec[CAUSE_CRC]       = crc_error_i;
  assign cause_vec[CAUSE_DEV_ERR]   = dev_err;
  assign cause_vec[CAUSE_WATCHDOG]  = wd_expired;
  assign cause_vec[CAUSE_USER_REQ]  = user_req;
  assign any_cause = (in_factory || in_app) && (cause_vec != '0);

  // Highest cause wins a tie, so the one-hot record stays one-hot
  assign cause_win =
    cause_vec[CAUSE_PIN_RESET] ? 5'h10 :
    cause_vec[CAUSE_CRC]       ? 5'h08 :
    cause_vec[CAUSE_DEV_ERR]   ? 5'h04 :
    cause_vec[CAUSE_WATCHDOG]  ? 5'h02 : 5'h01;

  // Factory may launch the application by user request only
  logic go_app;
  assign go_app      = in_factory && (cause_win == 5'h01) && remote_r;
  assign update_boot = {update_r[CTL_ADDR_MSB:CTL_ADDR_LSB], ADDR_PAD};
  assign next_boot   = go_app ? update_boot : factory_addr_r;

  // Address field preset at power up, chosen by configuration scheme
  logic [21:0] preset_field;
  assign preset_field = active_parallel_scheme_i ?
    addr_field(PARALLEL_FACTORY_ADDR) :
    addr_field(SERIAL_FACTORY_ADDR);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_POWERUP:
        if (straps_taken_r)
          state_nxt = ST_RECONFIG;
      ST_FACTORY,
      ST_APP:
        if (any_cause)
          state_nxt = ST_RECONFIG;
      ST_RECONFIG:
        if (config_complete_flag_i)
          state_nxt = target_app_r ? ST_APP : ST_FACTORY;
      default:
        state_nxt = ST_POWERUP;
    endcase
  end

  // Straps caught once after reset release, never under reset
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      straps_taken_r <= 1'b0;
      remote_r       <= 1'b0;
      parallel_r     <= 1'b0;
    end
    else if (!straps_taken_r)
    begin
      straps_taken_r <= 1'b1;
      remote_r       <= remote_mode_i;
      parallel_r     <= active_parallel_scheme_i;
    end
  end

  // Factory location, replaceable in the parallel scheme
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      factory_addr_r <= SERIAL_FACTORY_ADDR;
    else if (!straps_taken_r)
      factory_addr_r <= active_parallel_scheme_i ?
                        PARALLEL_FACTORY_ADDR :
                        SERIAL_FACTORY_ADDR;
    else if (factory_address_load_i && parallel_r)
      factory_addr_r <= factory_address_i;
  end

  // Edge history of synchronised levels
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rclk_d_r  <= 1'b0;
      reqn_d_r  <= 1'b1;
      rstn_d_r  <= 1'b1;
      errn_d_r  <= 1'b1;
      kickn_d_r <= 1'b1;
    end
    else
    begin
      rclk_d_r  <= rclk_lvl;
      reqn_d_r  <= reqn_lvl;
      rstn_d_r  <= rstn_lvl;
      errn_d_r  <= errn_lvl;
      kickn_d_r <= kickn_lvl;
    end
  end

  // Shift register follows register clock edges only; update also takes the power-up address preset
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      shift_r      <= '0;
      update_r     <= CTRL_RESET;
      serial_out_o <= 1'b0;
    end
    else
    begin
      shift_r      <= shift_nxt;
      serial_out_o <= shift_nxt[0];
      if (update_ok)
        update_r <= fix_reserved(shift_r);
      else if (!straps_taken_r)
        update_r[CTL_ADDR_MSB:CTL_ADDR_LSB] <= preset_field;
    end
  end

  // Control and status registers on the oscillator clock
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r      <= ST_POWERUP;
      target_app_r <= 1'b0;
      control_r    <= CTRL_RESET;
      cause_r      <= '0;
      cur_boot_r   <= SERIAL_FACTORY_ADDR;
    end
    else
    begin
      state_r <= state_nxt;
      if (!straps_taken_r)
        control_r[CTL_ADDR_MSB:CTL_ADDR_LSB] <= preset_field;
      else if (state_r == ST_POWERUP)
      begin
        target_app_r <= 1'b0;
        cur_boot_r   <= factory_addr_r;
      end
      else if (any_cause)
      begin
        control_r    <= fix_reserved(update_r);
        cause_r      <= cause_win;
        target_app_r <= go_app;
        cur_boot_r   <= next_boot;
      end
    end
  end

  // Engine-facing outputs
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reconfig_start_o   <= 1'b0;
      boot_address_o     <= SERIAL_FACTORY_ADDR;
      factory_image_o    <= 1'b0;
      early_done_check_o <= 1'b0;
      osc_select_o       <= 1'b0;
      watchdog_enable_o  <= 1'b0;
    end
    else
    begin
      reconfig_start_o   <= (state_nxt == ST_RECONFIG) &&
                            (state_r != ST_RECONFIG);
      boot_address_o     <= cur_boot_r;
      factory_image_o    <= in_factory;
      early_done_check_o <= control_r[CTL_EARLY_DN];
      osc_select_o       <= control_r[CTL_OSC_SEL];
      watchdog_enable_o  <= in_app && control_r[CTL_WDOG_ON];
    end
  end

  user_watchdog u_wdog (
    .mclk_i          (mclk_i),
    .reset_i         (reset_i),
    .enable_i        (in_app && control_r[CTL_WDOG_ON]),
    .kick_i          (kick),
    .timeout_field_i (control_r[CTL_WD_MSB:CTL_WD_LSB]),
    .expired_o       (wd_expired)
  );

endmodule : upgrade_regs

// file: upgrade_regs_monitor.sv
// Port checks for the image upgrade register block.
// Assumes one domain on mclk_i, reset_i asynchronous and active high.
`timescale 1ns/100ps
module upgrade_regs_monitor
  import upgrade_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      reset_i,
  input  wire logic                      upgrade_reg_clock_i,
  input  wire logic                      active_parallel_scheme_i,
  input  wire logic                      serial_out_o,
  input  wire logic [upgrade_pkg::ADDR_W-1:0] boot_address_o,
  input  wire logic                      reconfig_start_o,
  input  wire logic                      factory_image_o,
  input  wire logic                      early_done_check_o,
  input  wire logic                      osc_select_o,
  input  wire logic                      watchdog_enable_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_start_one_pulse: assert property (
    reconfig_start_o |=> !reconfig_start_o)
    else $error("start pulse longer than one cycle");
  a_start_ends_factory: assert property (
    reconfig_start_o |-> ##2 !factory_image_o)
    else $error("factory flag kept through reconfiguration");
  a_wd_app_only: assert property (
    watchdog_enable_o |-> !factory_image_o)
    else $error("watchdog enabled in factory image");
  a_boot_word_aligned: assert property (
    !active_parallel_scheme_i |-> boot_address_o[1:0] == 2'h0)
    else $error("boot address not padded with zeros");
  a_serial_factory_zero: assert property (
    factory_image_o && !active_parallel_scheme_i
      |-> boot_address_o == SERIAL_FACTORY_ADDR)
    else $error("serial factory boot address not zero");
  a_boot_moves_on_start: assert property (
    $changed(boot_address_o) |-> $past(reconfig_start_o))
    else $error("boot address changed outside reconfiguration");
  a_option_moves_on_start: assert property (
    $changed({early_done_check_o, osc_select_o})
      |-> $past(reconfig_start_o) || $past(reconfig_start_o, 2))
    else $error("option bits changed outside reconfiguration");
  a_shift_out_idle: assert property (
    $stable(upgrade_reg_clock_i) [*8] |=> $stable(serial_out_o))
    else $error("serial output moved without register clock");
endmodule : upgrade_regs_monitor

bind upgrade_regs upgrade_regs_monitor u_mon (.*);

// file: user_logic_model.sv
// Model of the logic-array user design driving the serial register port.
// Assumes pins change 1 ns after an mclk_i edge and are sampled by it.
`timescale 1ns/100ps
module user_logic_model
  import upgrade_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic serial_out_i,
  output logic      reg_clock_o,
  output logic      serial_in_o,
  output logic      shift_sel_o,
  output logic      capture_sel_o,
  output logic      status_sel_o
);
  // Five sampling cycles a level: slower than the pin allows, but the
  // block must see every level through its synchroniser
  localparam int HALF = 5;

  initial
  begin
    reg_clock_o   = 1'b0;
    serial_in_o   = 1'b0;
    shift_sel_o   = 1'b1;
    capture_sel_o = 1'b1;
    status_sel_o  = 1'b0;
  end

  task automatic half_wait();
    repeat (HALF) @(posedge mclk_i);
    #1;
  endtask : half_wait

  // Everything is set a half period ahead and held through the rise
  task automatic reg_cycle(input logic shift, input logic capt,
                           input logic stat, input logic din,
                           output logic dout);
    shift_sel_o   = shift;
    capture_sel_o = capt;
    status_sel_o  = stat;
    serial_in_o   = din;
    half_wait();
    dout = serial_out_i;
    reg_clock_o = 1'b1;
    half_wait();
    reg_clock_o = 1'b0;
  endtask : reg_cycle

  task automatic xfer(input logic [CTRL_W-1:0] d, input logic capt,
                      output logic [CTRL_W-1:0] q);
    for (int i = 0; i < CTRL_W; i++)
      reg_cycle(1'b1, capt, 1'b0, d[i], q[i]);
  endtask : xfer

  task automatic write_word(input logic [CTRL_W-1:0] d);
    logic [CTRL_W-1:0] q;
    logic              b;
    xfer(d, 1'b0, q);
    reg_cycle(1'b0, 1'b0, 1'b0, ~d[CTRL_W-1], b);
  endtask : write_word

  task automatic read_word(input logic stat, output logic [CTRL_W-1:0] q);
    logic b;
    reg_cycle(1'b0, 1'b1, stat, 1'b0, b);
    xfer('0, 1'b1, q);
    serial_in_o = 1'b1;
  endtask : read_word
endmodule : user_logic_model

// file: user_watchdog.sv
// User watchdog: 29-bit down counter reloaded by a kick pulse.
// Runs on the oscillator clock; enable comes from the control register.
`timescale 1ns/100ps
module user_watchdog
  import upgrade_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  input  wire logic                  enable_i,
  input  wire logic                  kick_i,
  input  wire logic [WD_FIELD_W-1:0] timeout_field_i,
  output logic                       expired_o
);

  logic [WD_CNT_W-1:0] count_r;
  logic [WD_CNT_W-1:0] load_val;
  logic                at_zero;

  assign load_val = {timeout_field_i, WD_LOW_PATTERN};
  assign at_zero  = (count_r == '0);

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_r   <= '0;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= enable_i && !kick_i && at_zero;
      if (!enable_i || kick_i || at_zero)
        count_r <= load_val;
      else
        count_r <= count_r - 1'b1;
    end
  end

endmodule : user_watchdog
